// ===== logic/sbcsr_pkg.sv
package sbcsr_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_PERIOD_NS  = 20;
  localparam int LINK_PERIOD_NS = 160;
  // half link period in system clocks, rounded down, at least one
  localparam int HALF_CYCLES    = (LINK_PERIOD_NS / (2 * SYS_PERIOD_NS)) < 1 ? 1 :
                                  (LINK_PERIOD_NS / (2 * SYS_PERIOD_NS));
  localparam int GAP_HALVES     = 2;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS  = 16;
  localparam int ADDR_BITS   = 7;
  localparam int WR_BIT_POS  = 7;
  localparam int DATA_LSB    = 8;
  localparam int CTRL_CNT    = 32;
  localparam int STAT_CNT    = 22;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [6:0] ADDR_MODE_SUPPLY   = 7'h01;
  localparam logic [6:0] ADDR_HW_CONFIG     = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG      = 7'h03;
  localparam logic [6:0] ADDR_BUS_XCVR      = 7'h04;
  localparam logic [6:0] ADDR_PEAK_TH       = 7'h05;
  localparam logic [6:0] ADDR_WAKE_ONE      = 7'h06;
  localparam logic [6:0] ADDR_WAKE_TWO      = 7'h07;
  localparam logic [6:0] ADDR_WAKE_PULL     = 7'h08;
  localparam logic [6:0] ADDR_WAKE_FILTER   = 7'h09;
  localparam logic [6:0] ADDR_TIMER_ONE     = 7'h0C;
  localparam logic [6:0] ADDR_TIMER_TWO     = 7'h0D;
  localparam logic [6:0] ADDR_SW_SHUTDOWN   = 7'h10;
  localparam logic [6:0] ADDR_HS_ONE        = 7'h14;
  localparam logic [6:0] ADDR_HS_TWO        = 7'h15;
  localparam logic [6:0] ADDR_PIN_IO        = 7'h17;
  localparam logic [6:0] ADDR_PULSE_ONE     = 7'h18;
  localparam logic [6:0] ADDR_PULSE_TWO     = 7'h19;
  localparam logic [6:0] ADDR_PULSE_FREQ    = 7'h1C;
  localparam logic [6:0] ADDR_SYS_SCRATCH   = 7'h1E;
  localparam logic [6:0] ADDR_EV_MASK       = 7'h1F;
  localparam logic [6:0] ADDR_SUPPLY_TWO    = 7'h40;
  localparam logic [6:0] ADDR_SUPPLY_ONE    = 7'h41;
  localparam logic [6:0] ADDR_THERMAL       = 7'h42;
  localparam logic [6:0] ADDR_DEVICE_STAT   = 7'h43;
  localparam logic [6:0] ADDR_BUS_STAT      = 7'h44;
  localparam logic [6:0] ADDR_WAKE_SRC_ONE  = 7'h46;
  localparam logic [6:0] ADDR_WAKE_SRC_TWO  = 7'h47;
  localparam logic [6:0] ADDR_WAKE_LEVEL    = 7'h48;
  localparam logic [6:0] ADDR_HS_FAULT      = 7'h54;
  localparam logic [6:0] ADDR_HS_OPEN_LOAD  = 7'h55;
  localparam logic [6:0] ADDR_EV_STAT       = 7'h70;
  localparam logic [6:0] ADDR_FAMILY_ID     = 7'h7E;
  localparam logic [1:0] AREA_CTRL          = 2'h0;
  localparam logic [1:0] AREA_STAT          = 2'h2;

  // ****************************************
  // reset, restart and field values
  // ****************************************
  localparam logic [7:0] CTRL_POR        = 8'h00;
  localparam logic [7:0] RST_MSC_CLR     = 8'hD8;  // mode and vcc2 field
  localparam logic [7:0] RST_HW_CLR      = 8'h26;
  localparam int         MODE_LSB        = 6;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  localparam logic [7:0] FAMILY_ID_VAL   = 8'h5A;  // arbitrary value
  localparam int         EV_BITS         = 3;
  localparam int         EV_DONE         = 0;
  localparam int         EV_LEN_ERR      = 1;
  localparam int         EV_UNMAPPED     = 2;

  // ****************************************
  // host register offsets
  // ****************************************
  localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_RX_OFS   = 8'h08;
  localparam int         HST_BUSY      = 0;
  localparam int         HST_DONE      = 1;

  typedef logic [CTRL_CNT-1:0][7:0] sbcsr_ctrl_t;
  typedef logic [STAT_CNT-1:0][7:0] sbcsr_stat_t;

  // writable bits of each control register, reserved bits are zero
  function automatic logic [7:0] ctrl_mask(input logic [6:0] a);
    case (a)
      ADDR_MODE_SUPPLY, ADDR_PIN_IO, ADDR_PULSE_ONE, ADDR_PULSE_TWO,
      ADDR_SYS_SCRATCH:                    ctrl_mask = 8'hFF;
      ADDR_HW_CONFIG:                      ctrl_mask = 8'hFB;
      ADDR_WATCHDOG:                       ctrl_mask = 8'hF7;
      ADDR_BUS_XCVR:                       ctrl_mask = 8'h03;
      ADDR_PEAK_TH:                        ctrl_mask = 8'h20;
      ADDR_WAKE_ONE:                       ctrl_mask = 8'hC4;
      ADDR_WAKE_TWO:                       ctrl_mask = 8'hA7;
      ADDR_WAKE_PULL, ADDR_WAKE_FILTER:    ctrl_mask = 8'h3F;
      ADDR_TIMER_ONE, ADDR_TIMER_TWO,
      ADDR_HS_ONE, ADDR_HS_TWO:            ctrl_mask = 8'h77;
      ADDR_SW_SHUTDOWN:                    ctrl_mask = 8'h70;
      ADDR_PULSE_FREQ:                     ctrl_mask = 8'h05;
      ADDR_EV_MASK:                        ctrl_mask = 8'h07;
      default:                             ctrl_mask = 8'h00;
    endcase
  endfunction

  // flag bits of each read-clear status register
  function automatic logic [7:0] stat_mask(input logic [6:0] a);
    case (a)
      ADDR_SUPPLY_TWO:                     stat_mask = 8'h5F;
      ADDR_SUPPLY_ONE:                     stat_mask = 8'hFE;
      ADDR_THERMAL, ADDR_BUS_STAT:         stat_mask = 8'h07;
      ADDR_DEVICE_STAT:                    stat_mask = 8'hCF;
      ADDR_WAKE_SRC_ONE:                   stat_mask = 8'h37;
      ADDR_WAKE_SRC_TWO:                   stat_mask = 8'h30;
      ADDR_HS_FAULT, ADDR_HS_OPEN_LOAD:    stat_mask = 8'h0F;
      default:                             stat_mask = 8'h00;
    endcase
  endfunction

endpackage

// ===== logic/sbcsr_link_if.sv
`timescale 1ns/1ps
interface sbcsr_link_if;
  logic sclk;     // shift clock, made by the host
  logic cs_b;     // frame select, active low
  logic mosi;     // host to device
  logic miso;     // device to host

  modport dev_mp  (input sclk, input cs_b, input mosi, output miso);
  modport host_mp (output sclk, output cs_b, output mosi, input miso);
endinterface

// ===== logic/sbcsr_sync.sv
`timescale 1ns/1ps
module sbcsr_sync #(
  parameter logic RST_VAL = 1'b0    // idle level of the pin
) (
  // clock and reset
  input  logic sys_clk,
  input  logic rst_b,
  // pin and synchronised copies
  input  logic din,
  output logic dout,
  output logic dlast
);

  logic meta_reg;

  // two flops against metastability, a third for edge finding
  // reset to the idle level so release shows no false edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
      dlast    <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
      dlast    <= dout;
    end
  end

endmodule

// ===== logic/sbcsr_dev.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module sbcsr_dev (
  // clock and reset
  input  logic                sys_clk,
  input  logic                rst_b,
  // serial link
  sbcsr_link_if.dev_mp        link,
  // control register contents
  output sbcsr_pkg::sbcsr_ctrl_t ctrl_regs,
  // internal updates of hardware-updatable bits
  input  logic                hw_wr_en,
  input  logic [4:0]          hw_wr_addr,
  input  logic [7:0]          hw_wr_data,
  input  logic [7:0]          hw_wr_mask,
  // restart entry, one-cycle pulse
  input  logic                restart_entry,
  // status events and levels
  input  sbcsr_pkg::sbcsr_stat_t stat_set,
  input  logic [7:0]          wake_level,
  // interrupt
  output logic                irq
);
  import sbcsr_pkg::*;

  // ****************************************
  // link synchronisers
  // ****************************************
  logic sclk_s, sclk_d, cs_s, cs_d, mosi_s;

  sbcsr_sync u_sclk (.sys_clk(sys_clk), .rst_b(rst_b), .din(link.sclk),
                     .dout(sclk_s), .dlast(sclk_d));
  // select idles high; a low reset value would fake a frame end after reset
  sbcsr_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .rst_b(rst_b), .din(link.cs_b),
                                     .dout(cs_s), .dlast(cs_d));
  sbcsr_sync u_mosi (.sys_clk(sys_clk), .rst_b(rst_b), .din(link.mosi),
                     .dout(mosi_s), .dlast());

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign cs_fall   = ~cs_s & cs_d;
  assign cs_rise   = cs_s & ~cs_d;
  assign in_frame  = ~cs_s;

  // ****************************************
  // state
  // ****************************************
  sbcsr_ctrl_t           ctrl_reg, ctrl_next;
  sbcsr_stat_t           stat_reg, stat_next;
  logic [EV_BITS-1:0]    ev_reg, ev_next;
  logic [15:0]           in_sr_reg;
  logic [4:0]            bit_cnt_reg;
  logic [6:0]            acc_addr_reg;
  logic                  acc_wr_reg;
  logic [7:0]            rd_snap_reg;
  logic [7:0]            out_sr_reg;
  logic                  miso_reg;
  logic                  irq_reg;
  logic                  frame_ok, frame_bad, soft_rst;
  logic [7:0]            wr_data;

  // ****************************************
  // read value of one address
  // ****************************************
  function automatic logic [7:0] rd_val(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[6:5] == AREA_CTRL)
      v = ctrl_reg[a[4:0]] & ctrl_mask(a);
    else if (a == ADDR_WAKE_LEVEL)
      v = wake_level;
    else if (a[6:5] == AREA_STAT)
      v = stat_reg[a[4:0]] & stat_mask(a);
    else if (a == ADDR_EV_STAT)
      v = {{(8-EV_BITS){1'b0}}, ev_reg};
    else if (a == ADDR_FAMILY_ID)
      v = FAMILY_ID_VAL;
    return v;
  endfunction

  function automatic logic mapped(input logic [6:0] a);
    return (ctrl_mask(a) != 8'h00) || (stat_mask(a) != 8'h00) ||
           (a == ADDR_WAKE_LEVEL) || (a == ADDR_EV_STAT) || (a == ADDR_FAMILY_ID);
  endfunction

  // ****************************************
  // shift in and frame bookkeeping
  // ****************************************
  // count saturates at 17 so an over-long frame is still seen as bad
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sr_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      in_sr_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (in_frame && sclk_rise) begin
      in_sr_reg <= {mosi_s, in_sr_reg[15:1]};    // bit 0 first
      if (bit_cnt_reg != 5'h11)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // address and direction are known at the eighth rising edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_addr_reg <= 7'h00;
      acc_wr_reg   <= 1'b0;
      rd_snap_reg  <= 8'h00;
    end else if (in_frame && sclk_rise && bit_cnt_reg == 5'(WR_BIT_POS)) begin
      acc_addr_reg <= in_sr_reg[15:9];
      acc_wr_reg   <= mosi_s;
      rd_snap_reg  <= rd_val(in_sr_reg[15:9]);
    end
  end

  // a frame counts only when exactly sixteen bits came before select rose
  assign frame_ok  = cs_rise && (bit_cnt_reg == 5'(FRAME_BITS));
  assign frame_bad = cs_rise && (bit_cnt_reg != 5'(FRAME_BITS));
  assign wr_data   = in_sr_reg[15:DATA_LSB];
  assign soft_rst  = frame_ok && acc_wr_reg && (acc_addr_reg == ADDR_MODE_SUPPLY) &&
                     (wr_data[MODE_LSB+1:MODE_LSB] == MODE_SOFT_RESET);

  // ****************************************
  // control registers
  // ****************************************
  // internal update first, then host write, then restart, then soft reset on top
  always_comb begin
    ctrl_next = ctrl_reg;
    for (int i = 0; i < CTRL_CNT; i++) begin
      if (hw_wr_en && hw_wr_addr == 5'(i))
        ctrl_next[i] = (ctrl_reg[i] & ~(hw_wr_mask & ctrl_mask(7'(i)))) |
                       (hw_wr_data & hw_wr_mask & ctrl_mask(7'(i)));
    end
    if (frame_ok && acc_wr_reg && acc_addr_reg[6:5] == AREA_CTRL)
      ctrl_next[acc_addr_reg[4:0]] = wr_data & ctrl_mask(acc_addr_reg);
    if (restart_entry) begin
      ctrl_next[ADDR_MODE_SUPPLY[4:0]] = ctrl_next[ADDR_MODE_SUPPLY[4:0]] &
                                         ~RST_MSC_CLR;
      ctrl_next[ADDR_HW_CONFIG[4:0]]   = ctrl_next[ADDR_HW_CONFIG[4:0]] &
                                         ~RST_HW_CLR;
    end
    if (soft_rst)
      ctrl_next = {CTRL_CNT{CTRL_POR}};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      ctrl_reg <= {CTRL_CNT{CTRL_POR}};
    else
      ctrl_reg <= ctrl_next;
  end

  assign ctrl_regs = ctrl_reg;

  // ****************************************
  // read-clear status registers
  // ****************************************
  // only the flags shifted out are cleared; a flag set meanwhile survives
  always_comb begin
    stat_next = stat_reg;
    if (frame_ok && !acc_wr_reg && acc_addr_reg[6:5] == AREA_STAT)
      stat_next[acc_addr_reg[4:0]] = stat_reg[acc_addr_reg[4:0]] & ~rd_snap_reg;
    if (soft_rst)
      stat_next = '0;
    for (int i = 0; i < STAT_CNT; i++)
      stat_next[i] = stat_next[i] | (stat_set[i] & stat_mask({AREA_STAT, 5'(i)}));
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      stat_reg <= '0;
    else
      stat_reg <= stat_next;
  end

  // ****************************************
  // link events and interrupt
  // ****************************************
  // events set after the clear so a new event is never lost
  always_comb begin
    ev_next = ev_reg;
    if (frame_ok && !acc_wr_reg && acc_addr_reg == ADDR_EV_STAT)
      ev_next = ev_reg & ~rd_snap_reg[EV_BITS-1:0];
    if (frame_ok)
      ev_next[EV_DONE] = 1'b1;
    if (frame_bad)
      ev_next[EV_LEN_ERR] = 1'b1;
    if (frame_ok && !mapped(acc_addr_reg))
      ev_next[EV_UNMAPPED] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_reg  <= '0;
      irq_reg <= 1'b0;
    end else begin
      ev_reg  <= ev_next;
      irq_reg <= |(ev_reg & ctrl_reg[ADDR_EV_MASK[4:0]][EV_BITS-1:0]);
    end
  end

  assign irq = irq_reg;

  // ****************************************
  // shift out
  // ****************************************
  // first byte carries the event flags, second the register contents
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sr_reg <= 8'h00;
      miso_reg   <= 1'b0;
    end else if (cs_fall) begin
      miso_reg   <= ev_reg[0];
      out_sr_reg <= {{(9-EV_BITS){1'b0}}, ev_reg[EV_BITS-1:1]};
    end else if (!in_frame) begin
      miso_reg   <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg == 5'(WR_BIT_POS)) begin
      out_sr_reg <= rd_val(in_sr_reg[15:9]);
    end else if (sclk_fall) begin
      miso_reg   <= out_sr_reg[0];
      out_sr_reg <= {1'b0, out_sr_reg[7:1]};
    end
  end

  assign link.miso = miso_reg;

endmodule

// ===== logic/sbcsr_host.sv
`timescale 1ns/1ps
module sbcsr_host (
  // clock and reset
  input  logic        sys_clk,
  input  logic        rst_b,
  // apb slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // serial link
  sbcsr_link_if.host_mp link
);
  import sbcsr_pkg::*;

  typedef enum {SBCSR_IDLE, SBCSR_SHIFT, SBCSR_GAP} sbcsr_state_e;

  sbcsr_state_e state_reg;
  logic [15:0]  tx_reg, rx_reg;
  logic [2:0]   div_reg;
  logic [3:0]   idx_reg;
  logic [1:0]   gap_reg;
  logic         sclk_reg, cs_b_reg, mosi_reg, done_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         miso_s, tick, start, stat_rd;

  sbcsr_sync u_miso (.sys_clk(sys_clk), .rst_b(rst_b), .din(link.miso),
                     .dout(miso_s), .dlast());

  // ****************************************
  // apb access
  // ****************************************
  assign start   = psel && penable && pready_reg && pwrite &&
                   paddr == HOST_CMD_OFS && state_reg == SBCSR_IDLE;
  assign stat_rd = psel && penable && pready_reg && !pwrite && paddr == HOST_STAT_OFS;

  // read data is prepared in the setup cycle, so no wait state is needed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (psel && !penable) begin
        case (paddr)
          HOST_STAT_OFS: prdata_reg <= {30'h0, done_reg, state_reg != SBCSR_IDLE};
          HOST_RX_OFS:   prdata_reg <= {16'h0000, rx_reg};
          default:       prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = 1'b0;

  // done is sticky; a new completion wins over the clearing read, and a read
  // clears only a completion that it reported, so none is lost unseen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      done_reg <= 1'b0;
    else if (state_reg == SBCSR_GAP && tick && gap_reg == 2'(GAP_HALVES - 1))
      done_reg <= 1'b1;
    else if (stat_rd && prdata_reg[HST_DONE])
      done_reg <= 1'b0;
  end

  // ****************************************
  // link clock divider
  // ****************************************
  assign tick = (div_reg == 3'(HALF_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      div_reg <= 3'h0;
    else if (state_reg == SBCSR_IDLE || tick)
      div_reg <= 3'h0;
    else
      div_reg <= div_reg + 3'h1;
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  // commands while busy are dropped; software waits for the done bit first
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SBCSR_IDLE;
      tx_reg    <= 16'h0000;
      rx_reg    <= 16'h0000;
      idx_reg   <= 4'h0;
      gap_reg   <= 2'h0;
      sclk_reg  <= 1'b0;
      cs_b_reg  <= 1'b1;
      mosi_reg  <= 1'b0;
    end else begin
      case (state_reg)
        SBCSR_IDLE: begin
          if (start) begin
            tx_reg    <= pwdata[15:0];   // address, direction, data: one frame
            mosi_reg  <= pwdata[0];
            cs_b_reg  <= 1'b0;
            idx_reg   <= 4'h0;
            state_reg <= SBCSR_SHIFT;
          end
        end
        SBCSR_SHIFT: begin
          if (tick) begin
            if (!sclk_reg) begin
              sclk_reg <= 1'b1;
            end else begin
              sclk_reg        <= 1'b0;
              rx_reg[idx_reg] <= miso_s;
              if (idx_reg == 4'(FRAME_BITS - 1)) begin
                cs_b_reg  <= 1'b1;
                gap_reg   <= 2'h0;
                state_reg <= SBCSR_GAP;
              end else begin
                idx_reg  <= idx_reg + 4'h1;
                mosi_reg <= tx_reg[idx_reg + 4'h1];
              end
            end
          end
        end
        SBCSR_GAP: begin
          if (tick) begin
            gap_reg <= gap_reg + 2'h1;
            if (gap_reg == 2'(GAP_HALVES - 1))
              state_reg <= SBCSR_IDLE;
          end
        end
        default: state_reg <= SBCSR_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_b = cs_b_reg;
  assign link.mosi = mosi_reg;

endmodule

// ===== testbench/sbcsr_chk.sv
`timescale 1ns/1ps
module sbcsr_chk (
  // clock and reset
  input logic sys_clk,
  input logic rst_b,
  // link wires
  input logic sclk,
  input logic cs_b,
  input logic mosi,
  input logic miso
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] bit_cnt;
  // shift edges seen in the running frame, cleared between frames
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) bit_cnt <= 5'h00;
    else if (cs_b) bit_cnt <= 5'h00;
    else if ($rose(sclk)) bit_cnt <= bit_cnt + 5'h01;
  end
  // ****
  // wire rules
  // ****
  a_frame_len: assert property ($rose(cs_b) |-> bit_cnt == 5'h10)
    else $error("frame length wrong");
  a_sclk_idle: assert property (cs_b |-> !sclk)
    else $error("shift clock outside frame");
  a_lead_in: assert property ($fell(cs_b) |-> ##[3:5] $rose(sclk))
    else $error("first shift edge late");
  a_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("high half wrong");
  a_low_half: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("low half short");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sampled");
  a_miso_hold: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sampled");
  a_miso_idle: assert property (cs_b[*8] |-> !miso)
    else $error("miso not idle");
  a_frame_gap: assert property ($rose(cs_b) |-> cs_b[*4])
    else $error("frames too close");
endmodule

// ===== testbench/sbc_spi_register_bank_tb_top.sv
`timescale 1ns/1ps
module sbc_spi_register_bank_tb_top;
  import sbcsr_pkg::*;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic        hw_wr_en, restart_entry;
  logic [7:0]  paddr, hw_wr_data, hw_wr_mask, wake_level, q, d;
  logic [31:0] pwdata, prdata, r;
  logic [4:0]  hw_wr_addr;
  logic [6:0]  a;
  sbcsr_ctrl_t ctrl_regs;
  sbcsr_stat_t stat_set;
  logic [7:0]  m [32];
  // writable bits per control address, reserved bits stay zero
  logic [7:0]  wm [32] = '{8'h00, 8'hFF, 8'hFB, 8'hF7, 8'h03, 8'h20, 8'hC4, 8'hA7, 8'h3F,
    8'h3F, 8'h00, 8'h00, 8'h77, 8'h77, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h77, 8'h77,
    8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h05, 8'h00, 8'hFF, 8'h07};
  int          error_cnt, checked;
  sbcsr_link_if link ();
  sbcsr_dev i_sbcsr_dev (.sys_clk, .rst_b, .link(link), .ctrl_regs, .hw_wr_en, .hw_wr_addr,
    .hw_wr_data, .hw_wr_mask, .restart_entry, .stat_set, .wake_level, .irq);
  sbcsr_host i_sbcsr_host (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link));
  sbcsr_chk i_sbcsr_chk (.sys_clk, .rst_b, .sclk(link.sclk), .cs_b(link.cs_b),
    .mosi(link.mosi), .miso(link.miso));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string t);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: %s saw %h want %h", $time, t, s, e);
    end
  endtask
  // one idle cycle before each setup keeps a signal from being driven twice at one edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk) penable <= 1'b1;
    // wait for ready however long; only the watchdog ends a hang
    do @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one whole frame: command, wait for done, fetch the register byte
  task automatic frame(input logic [6:0] fa, input logic fw, input logic [7:0] fd,
                       output logic [7:0] fq);
    apb(1'b1, HOST_CMD_OFS, {16'h0000, fd, fw, fa}, r);
    do
      apb(1'b0, HOST_STAT_OFS, 32'h0, r);
    while (r[HST_DONE] !== 1'b1);
    chk({7'h0, r[HST_BUSY]}, 8'h00, "busy after done");
    apb(1'b0, HOST_RX_OFS, 32'h0, r);
    fq = r[15:8];
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // free running system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // watchdog, far beyond the expected run of about ten thousand cycles
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  // ****
  // tests
  // ****
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, hw_wr_en, restart_entry} = '0;
    {hw_wr_addr, hw_wr_data, hw_wr_mask, wake_level, stat_set} = '0;
    r = $urandom(69);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    for (int i = 0; i < 30; i++) begin
      a = 7'($urandom_range(31));
      d = 8'($urandom);
      if (a == ADDR_MODE_SUPPLY) d[7] = 1'b0; // no soft reset here
      frame(a, 1'b1, d, q);
      chk(q, m[a], "old value");
      m[a] = d & wm[a];
      frame(a, 1'b0, 8'($urandom), q);
      chk(q, m[a], "read back");
      chk(ctrl_regs[a[4:0]], m[a], "ctrl port");
    end
    $display("test control done");
    frame(ADDR_EV_MASK, 1'b1, 8'h07, q);
    chk({7'h0, irq}, 8'h01, "irq enabled");
    frame(7'h20, 1'b1, 8'hFF, q);
    chk(q, 8'h00, "hole write");
    frame(7'h20, 1'b0, 8'h00, q);
    chk(q, 8'h00, "hole read");
    frame(ADDR_EV_STAT, 1'b0, 8'h00, q);
    chk(q, 8'h05, "events");
    frame(ADDR_EV_MASK, 1'b1, 8'h00, q);
    m[31] = 8'h00;
    chk({7'h0, irq}, 8'h00, "irq closed");
    apb(1'b0, 8'h0C, 32'h0, r);
    chk({7'h0, |r}, 8'h00, "apb hole");
    $display("test events done");
    stat_set[2] <= 8'hFF;
    @(posedge sys_clk) stat_set[2] <= 8'h00;
    frame(ADDR_THERMAL, 1'b0, 8'h00, q);
    chk(q, 8'h07, "flags");
    frame(ADDR_THERMAL, 1'b1, 8'hFF, q);
    chk(q, 8'h00, "cleared");
    frame(ADDR_THERMAL, 1'b0, 8'h00, q);
    chk(q, 8'h00, "write ignored");
    wake_level <= 8'($urandom);
    frame(ADDR_WAKE_LEVEL, 1'b1, ~wake_level, q);
    chk(q, wake_level, "level");
    frame(ADDR_FAMILY_ID, 1'b1, 8'h00, q);
    frame(ADDR_FAMILY_ID, 1'b0, 8'h00, q);
    chk(q, FAMILY_ID_VAL, "family");
    $display("test status done");
    hw_wr_addr <= 5'h03;
    hw_wr_data <= 8'($urandom);
    hw_wr_mask <= 8'($urandom);
    hw_wr_en <= 1'b1;
    @(posedge sys_clk) hw_wr_en <= 1'b0;
    m[3] = (m[3] & ~hw_wr_mask | hw_wr_data & hw_wr_mask) & wm[3];
    frame(ADDR_WATCHDOG, 1'b0, 8'h00, q);
    chk(q, m[3], "hw update");
    frame(ADDR_MODE_SUPPLY, 1'b1, 8'h5B, q);
    restart_entry <= 1'b1;
    @(posedge sys_clk) restart_entry <= 1'b0;
    m[1] = 8'h5B & 8'h27;
    m[2] = m[2] & 8'hD9;
    repeat (3) @(posedge sys_clk);
    for (int i = 1; i < 3; i++) chk(ctrl_regs[i], m[i], "restart");
    stat_set[2] <= 8'h01;
    @(posedge sys_clk) stat_set[2] <= 8'h00;
    frame(ADDR_MODE_SUPPLY, 1'b1, 8'hC0, q);
    for (int i = 0; i < 32; i++) chk(ctrl_regs[i], 8'h00, "soft reset");
    frame(ADDR_THERMAL, 1'b0, 8'h00, q);
    chk(q, 8'h00, "status reset");
    $display("test reset done");
    wrap_up();
  end
endmodule
